// File: common/ibw_pkg.sv
// Shared constants, port carrier type and sequencer states for the I2C byte write block
// Operation
// - Opcode 0x11 shifts bytes out MSB first, data changing on falling clock.
// - Two length bytes after 0x11 hold byte count minus one.
// - Opcode 0x80 takes value then direction; 0xFE/0xFB parks clock low, data released.
// - Port bit 0 is clock, bit 1 open-drain data out, bit 2 data in.
// - Opcode 0x22 samples data in on rising clock; length byte is bits minus one.
// - A short bit read returns a whole byte, last sampled bit in the LSB.
// - Opcode 0x87 forwards gathered result bytes to host at once.
// - Opcodes execute strictly in arrival order, each finished before the next.
// - Without 0x87, results wait for the latency timer, by default 16 ms.
package ibw_pkg;

  // Opcodes
  localparam logic [7:0] OP_BYTE_OUT  = 8'h11;
  localparam logic [7:0] OP_BIT_IN    = 8'h22;
  localparam logic [7:0] OP_PIN_WRITE = 8'h80;
  localparam logic [7:0] OP_SEND_NOW  = 8'h87;

  // Low port bit positions
  localparam int SCL_BIT     = 0;
  localparam int SDA_OUT_BIT = 1;
  localparam int SDA_IN_BIT  = 2;

  // Port state after reset: every pin an input, values high
  localparam logic [7:0] PORT_VALUE_RST = 8'hFF;
  localparam logic [7:0] PORT_DIR_RST   = 8'h00;

  // Timing
  localparam int CLK_PERIOD_NS  = 100;
  localparam int LINK_HALF_NS   = 400;
  localparam int HALF_CYC       = (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LATENCY_MS     = 16;
  localparam int LATENCY_CYC    = (LATENCY_MS * 1000000) / CLK_PERIOD_NS;

  // Value and direction of the low port travel together
  typedef struct packed {
    logic [7:0] value;
    logic [7:0] dir;
  } ibw_port_t;

  // Clock phase inside one serial bit
  typedef enum logic [2:0] {
    PH_FALL = 3'b001,
    PH_RISE = 3'b010,
    PH_TAIL = 3'b100
  } ibw_phase_t;

  typedef enum logic [9:0] {
    ST_IDLE    = 10'b0000000001,
    ST_LEN_LO  = 10'b0000000010,
    ST_LEN_HI  = 10'b0000000100,
    ST_PAYLOAD = 10'b0000001000,
    ST_SHOUT   = 10'b0000010000,
    ST_PIN_VAL = 10'b0000100000,
    ST_PIN_DIR = 10'b0001000000,
    ST_BIT_LEN = 10'b0010000000,
    ST_SHIN    = 10'b0100000000,
    ST_PUSH    = 10'b1000000000
  } ibw_state_t;

endpackage : ibw_pkg

// File: design/ibw_sequencer.sv
// Command sequencer: opcode bytes in, serial clock/data on the low port, result bytes out
`timescale 1ns/100ps
`default_nettype none
module ibw_sequencer #(
  parameter int LATENCY_CYCLES = ibw_pkg::LATENCY_CYC
) (
  input  wire logic       clk_sys,  // System clock, 10 MHz
  input  wire logic       resetn,   // Async reset, active low
  input  wire logic [7:0] rxData,   // Command byte from receive FIFO
  input  wire logic       rxValid,  // Receive FIFO holds a byte
  output var  logic       rxReady,  // Byte taken when high with rxValid
  output var  logic [7:0] txData,   // Result byte toward host
  output var  logic       txValid,  // Result byte offered
  input  wire logic       txReady,  // Transmit FIFO accepts
  output var  logic       txFlush,  // Pulse: send gathered results now
  input  wire logic [7:0] pinIn,    // Low port pin levels (async)
  output var  logic [7:0] pinOut,   // Low port output values
  output var  logic [7:0] pinOe     // Low port output enables, high drives
);

  ibw_pkg::ibw_state_t state;
  ibw_pkg::ibw_phase_t phase;
  ibw_pkg::ibw_port_t  lowPort;
  logic [15:0]         byteCnt;
  logic [2:0]          bitCnt;
  logic [7:0]          outShift;
  logic [7:0]          inShift;
  logic [7:0]          pinMeta;
  logic [7:0]          pinSync;
  logic                tick;
  logic                take;
  logic                shifting;
  logic                sendNow;
  logic                pending;
  logic [31:0]         latCount;
  logic                latExpire;

  assign take     = rxValid && rxReady;
  assign shifting = (state == ibw_pkg::ST_SHOUT) || (state == ibw_pkg::ST_SHIN);
  assign sendNow  = take && (state == ibw_pkg::ST_IDLE) && (rxData == ibw_pkg::OP_SEND_NOW);

  ibw_tick_gen #(
    .HALF (ibw_pkg::HALF_CYC)
  ) u_tick (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .run     (shifting),
    .tick    (tick)
  );

  // Two-flop synchroniser on the pins; only the second stage is read
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pinMeta <= 8'hFF;
      pinSync <= 8'hFF;
    end else begin
      pinMeta <= pinIn;
      pinSync <= pinMeta;
    end
  end

  // One byte at a time; ready drops for a cycle after each take
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rxReady <= 1'b0;
    end else begin
      rxReady <= !take && !shifting && (state != ibw_pkg::ST_PUSH);
    end
  end

  // Main sequencer and port state
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state         <= ibw_pkg::ST_IDLE;
      phase         <= ibw_pkg::PH_FALL;
      lowPort.value <= ibw_pkg::PORT_VALUE_RST;
      lowPort.dir   <= ibw_pkg::PORT_DIR_RST;
      byteCnt       <= 16'h0000;
      bitCnt        <= 3'h0;
      outShift      <= 8'h00;
      inShift       <= 8'h00;
    end else begin
      unique case (state)
        ibw_pkg::ST_IDLE: begin
          // Each opcode runs to completion before the next is looked at
          if (take) begin
            if (rxData == ibw_pkg::OP_BYTE_OUT) begin
              state <= ibw_pkg::ST_LEN_LO;
            end else if (rxData == ibw_pkg::OP_PIN_WRITE) begin
              state <= ibw_pkg::ST_PIN_VAL;
            end else if (rxData == ibw_pkg::OP_BIT_IN) begin
              state <= ibw_pkg::ST_BIT_LEN;
            end
            // Send-now and unknown opcodes finish in this one byte
          end
        end
        ibw_pkg::ST_LEN_LO: begin
          if (take) begin
            byteCnt[7:0] <= rxData;
            state        <= ibw_pkg::ST_LEN_HI;
          end
        end
        ibw_pkg::ST_LEN_HI: begin
          if (take) begin
            byteCnt[15:8] <= rxData;
            state         <= ibw_pkg::ST_PAYLOAD;
          end
        end
        ibw_pkg::ST_PAYLOAD: begin
          // Empty FIFO here just waits; clock stays low, data as last shifted
          if (take) begin
            outShift <= rxData;
            bitCnt   <= 3'h7;
            phase    <= ibw_pkg::PH_FALL;
            state    <= ibw_pkg::ST_SHOUT;
          end
        end
        ibw_pkg::ST_SHOUT: begin
          if (tick) begin
            unique case (phase)
              ibw_pkg::PH_FALL: begin
                lowPort.value[ibw_pkg::SCL_BIT]     <= 1'b0;
                lowPort.value[ibw_pkg::SDA_OUT_BIT] <= outShift[7];
                phase                               <= ibw_pkg::PH_RISE;
              end
              ibw_pkg::PH_RISE: begin
                lowPort.value[ibw_pkg::SCL_BIT] <= 1'b1;
                if (bitCnt == 3'h0) begin
                  phase <= ibw_pkg::PH_TAIL;
                end else begin
                  outShift <= {outShift[6:0], 1'b0};
                  bitCnt   <= bitCnt - 3'h1;
                  phase    <= ibw_pkg::PH_FALL;
                end
              end
              ibw_pkg::PH_TAIL: begin
                // Leave the clock low so the host can release data for acknowledge
                lowPort.value[ibw_pkg::SCL_BIT] <= 1'b0;
                phase                           <= ibw_pkg::PH_FALL;
                if (byteCnt == 16'h0000) begin
                  state <= ibw_pkg::ST_IDLE;
                end else begin
                  byteCnt <= byteCnt - 16'h0001;
                  state   <= ibw_pkg::ST_PAYLOAD;
                end
              end
              default: phase <= ibw_pkg::PH_FALL;
            endcase
          end
        end
        ibw_pkg::ST_PIN_VAL: begin
          if (take) begin
            outShift <= rxData;  // Value held until direction arrives
            state    <= ibw_pkg::ST_PIN_DIR;
          end
        end
        ibw_pkg::ST_PIN_DIR: begin
          // Value and direction change together, never a half-written port
          if (take) begin
            lowPort.value <= outShift;
            lowPort.dir   <= rxData;
            state         <= ibw_pkg::ST_IDLE;
          end
        end
        ibw_pkg::ST_BIT_LEN: begin
          if (take) begin
            bitCnt  <= rxData[2:0];
            inShift <= 8'h00;
            phase   <= ibw_pkg::PH_FALL;
            state   <= ibw_pkg::ST_SHIN;
          end
        end
        ibw_pkg::ST_SHIN: begin
          if (tick) begin
            unique case (phase)
              ibw_pkg::PH_FALL: begin
                lowPort.value[ibw_pkg::SCL_BIT] <= 1'b0;
                phase                           <= ibw_pkg::PH_RISE;
              end
              ibw_pkg::PH_RISE: begin
                // Slave's level sampled on the rising edge, oldest bit moves up
                lowPort.value[ibw_pkg::SCL_BIT] <= 1'b1;
                inShift <= {inShift[6:0], pinSync[ibw_pkg::SDA_IN_BIT]};
                if (bitCnt == 3'h0) begin
                  phase <= ibw_pkg::PH_TAIL;
                end else begin
                  bitCnt <= bitCnt - 3'h1;
                  phase  <= ibw_pkg::PH_FALL;
                end
              end
              ibw_pkg::PH_TAIL: begin
                lowPort.value[ibw_pkg::SCL_BIT] <= 1'b0;
                phase                           <= ibw_pkg::PH_FALL;
                state                           <= ibw_pkg::ST_PUSH;
              end
              default: phase <= ibw_pkg::PH_FALL;
            endcase
          end
        end
        ibw_pkg::ST_PUSH: begin
          // Next opcode waits until the result is handed on
          if (txValid && txReady) begin
            state <= ibw_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Result byte held until the transmit FIFO takes it
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      txValid <= 1'b0;
      txData  <= 8'h00;
    end else if (txValid) begin
      if (txReady) begin
        txValid <= 1'b0;
      end
    end else if (state == ibw_pkg::ST_SHIN && tick && phase == ibw_pkg::PH_TAIL) begin
      txValid <= 1'b1;
      txData  <= inShift;
    end
  end

  // Latency timer: runs while results sit unflushed
  assign latExpire = pending && (latCount >= 32'(LATENCY_CYCLES - 1));

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pending  <= 1'b0;
      latCount <= 32'h00000000;
      txFlush  <= 1'b0;
    end else begin
      txFlush <= sendNow || latExpire;
      // A byte handed over in the flush cycle keeps the timer armed
      if (txValid && txReady) begin
        pending  <= 1'b1;
        latCount <= 32'h00000000;
      end else if (sendNow || latExpire) begin
        pending  <= 1'b0;
        latCount <= 32'h00000000;
      end else if (pending) begin
        latCount <= latCount + 32'h00000001;
      end
    end
  end

  // Pin drive: clock push-pull, data out open-drain, data in never driven
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pinOut <= 8'h00;
      pinOe  <= 8'h00;
    end else begin
      pinOut                      <= lowPort.value;
      pinOut[ibw_pkg::SDA_OUT_BIT] <= 1'b0;
      pinOut[ibw_pkg::SDA_IN_BIT]  <= 1'b0;
      pinOe                       <= lowPort.dir;
      pinOe[ibw_pkg::SDA_OUT_BIT]  <= lowPort.dir[ibw_pkg::SDA_OUT_BIT] &&
                                      !lowPort.value[ibw_pkg::SDA_OUT_BIT];
      pinOe[ibw_pkg::SDA_IN_BIT]   <= 1'b0;
    end
  end

endmodule : ibw_sequencer
`default_nettype wire

// File: design/ibw_tick_gen.sv
// Half-bit enable pulse generator for the serial clock
`timescale 1ns/100ps
`default_nettype none
module ibw_tick_gen #(
  parameter int HALF = 4
) (
  input  wire logic clk_sys,  // System clock
  input  wire logic resetn,   // Async reset, active low
  input  wire logic run,      // Count while high, restart when low
  output var  logic tick      // One-cycle pulse every HALF cycles
);

  logic [15:0] count;

  // Restarting on idle keeps the first half bit full length
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count <= 16'h0000;
      tick  <= 1'b0;
    end else if (!run) begin
      count <= 16'h0000;
      tick  <= 1'b0;
    end else if (count == 16'(HALF - 1)) begin
      count <= 16'h0000;
      tick  <= 1'b1;
    end else begin
      count <= count + 16'h0001;
      tick  <= 1'b0;
    end
  end

endmodule : ibw_tick_gen
`default_nettype wire

// File: testbench/ibw_sequencer_assertions.sv
// Port-level assertions for the I2C byte write sequencer
`timescale 1ns/100ps
`default_nettype none
module ibw_sequencer_assertions #(
  parameter int LATENCY_CYCLES = 200
) (
  input wire logic       clk_sys,  // System clock
  input wire logic       resetn,   // Async reset, active low
  input wire logic [7:0] rxData,   // Command byte
  input wire logic       rxValid,  // Command byte offered
  input wire logic       rxReady,  // Command byte accepted
  input wire logic [7:0] txData,   // Result byte
  input wire logic       txValid,  // Result offered
  input wire logic       txReady,  // Result accepted
  input wire logic       txFlush,  // Send-now pulse
  input wire logic [7:0] pinIn,    // Pin levels
  input wire logic [7:0] pinOut,   // Pin values
  input wire logic [7:0] pinOe     // Pin enables
);
  logic        armed;    // Results handed since the last flush
  logic [31:0] waitCnt;  // Cycles the latency timer has run
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Mirror of the latency timer; a hand-over always restarts it
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      armed   <= 1'h0;
      waitCnt <= 32'h0;
    end else begin
      armed   <= (txValid && txReady) || (armed && !txFlush);
      waitCnt <= (txValid && txReady) || txFlush ? 32'h0 : waitCnt + 32'h1;
    end
  end
  sequence take_send_now;
    rxValid && rxReady && rxData == 8'h87;
  endsequence
  sequence stalled;
    (rxReady && !rxValid) [*3];
  endsequence
  sequence clock_rise;
    $rose(pinOut[0]) && pinOe[0];
  endsequence
  a_rx_one_gap: assert property (rxValid && rxReady |=> !rxReady)
    else $error("byte taken without a gap");
  a_flush_on_cmd: assert property (take_send_now |-> ##[1:2] txFlush)
    else $error("send-now did not flush");
  a_flush_single: assert property (txFlush |=> !txFlush)
    else $error("flush longer than one cycle");
  a_tx_held: assert property (txValid && !txReady |=> txValid && $stable(txData))
    else $error("result dropped before accepted");
  a_data_pins_legal: assert property (pinOe[2] == 1'h0 && pinOut[2:1] == 2'h0)
    else $error("data pins driven high or input driven");
  a_clock_half_bit: assert property (clock_rise |-> pinOut[0] [*4] ##1 !pinOut[0])
    else $error("clock high phase not four cycles");
  a_data_on_low: assert property ($changed(pinOe[1]) && pinOe[0] |-> !pinOut[0])
    else $error("data changed while clock high");
  a_pins_held: assert property (stalled |=> $stable(pinOut) && $stable(pinOe))
    else $error("pins moved while stalled");
  a_latency_bound: assert property (!(armed && waitCnt > LATENCY_CYCLES + 2))
    else $error("results not flushed by latency timer");
endmodule : ibw_sequencer_assertions

bind ibw_sequencer ibw_sequencer_assertions #(.LATENCY_CYCLES(LATENCY_CYCLES)) chk_u (
  .clk_sys(clk_sys), .resetn(resetn), .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady),
  .txData(txData), .txValid(txValid), .txReady(txReady), .txFlush(txFlush), .pinIn(pinIn),
  .pinOut(pinOut), .pinOe(pinOe));
`default_nettype wire

// File: testbench/ibw_sequencer_bench.sv
// Self-checking bench: byte writes with acknowledge check, bit reads, latency flush
`timescale 1ns/100ps
`default_nettype none
module ibw_sequencer_bench;
  localparam int LAT   = 200;    // Shortened latency timer
  localparam int LIMIT = 20000;  // Cycle ceiling for the run
  logic        clk_sys, resetn, rxValid, rxReady, txValid, txReady, txFlush, ackEn;
  logic [7:0]  rxData, txData, pinIn, pinOut, pinOe, slvByte, d;
  logic [31:0] seed = 32'hD640;
  int          failures = 0, cmp_count = 0, cyc = 0, takeCyc = 0, dt;
  logic [7:0]  expQ[$];

  ibw_sequencer #(.LATENCY_CYCLES(LAT)) dut_u (.clk_sys(clk_sys), .resetn(resetn), .rxData(rxData),
    .rxValid(rxValid), .rxReady(rxReady), .txData(txData), .txValid(txValid), .txReady(txReady),
    .txFlush(txFlush), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));
  ibw_slave_model slave_u (.resetn(resetn), .ackEn(ackEn), .pinOut(pinOut), .pinOe(pinOe),
    .pinIn(pinIn), .rxByte(slvByte));

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task test_done();
    $display("Compares %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  // Random idle gaps stall the sequencer mid-command
  task put(input logic [7:0] b);
    repeat (1 + rnd() % 3) @(negedge clk_sys);
    rxData  = b;
    rxValid = 1'h1;
    @(posedge clk_sys);
    while (rxReady !== 1'h1) @(posedge clk_sys);
    @(negedge clk_sys);
    rxValid = 1'h0;
  endtask : put

  // Host polls a bounded number of times, then reports the result as lost
  task wait_flush();
    for (int i = 0; i < 500 && txFlush !== 1'h1; i++) @(posedge clk_sys);
    check(8'(txFlush), 8'h01);
  endtask : wait_flush

  initial begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Transmit side stalls at random
  always @(negedge clk_sys) txReady = (rnd() % 4) != 0;

  // Result watcher and run ceiling; values seen are those the design sampled
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == LIMIT) begin
      failures++;
      test_done();
    end else if (txValid === 1'h1 && txReady === 1'h1) begin
      takeCyc = cyc;
      check(txData, expQ.size() > 0 ? expQ.pop_front() : 8'hXX);
    end
  end

  initial begin
    resetn  = 1'h0;
    rxValid = 1'h0;
    rxData  = 8'h00;
    ackEn   = 1'h0;
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    resetn = 1'h1;
    // Park clock low, data released, before any byte goes out
    put(8'h80); put(8'hFE); put(8'hFB);
    repeat (4) @(negedge clk_sys);
    check(pinOe, 8'hF9);
    check(pinOut, 8'hF8);
    $display("pin setup test done");
    // Byte writes; the first two carry address 0x22 for write and read
    for (int i = 0; i < 6; i++) begin
      d = i < 2 ? {7'h22, i[0]} : 8'(rnd());
      if (d == 8'h87) d = 8'h86;
      ackEn = 1'(rnd() % 2);
      expQ.push_back({7'h00, !ackEn});
      put(8'h11); put(8'h00); put(8'h00); put(d);
      put(8'h80); put(8'hFE); put(8'hFB);
      put(8'h22); put(8'h00); put(8'h87);
      wait_flush();
      check(slvByte, d);
      $display("byte write test %0d done", i);
    end
    // Single bit read without send-now waits for the latency timer
    ackEn = 1'h0;
    expQ.push_back(8'h01);
    put(8'h22); put(8'h00);
    wait_flush();
    dt = cyc - takeCyc;
    check({7'h00, dt >= LAT - 1 && dt <= LAT + 3}, 8'h01);
    $display("latency flush test done");
    // Full eight-bit read of a released line
    expQ.push_back(8'hFF);
    put(8'h22); put(8'h07); put(8'h87);
    wait_flush();
    repeat (4) @(negedge clk_sys);
    check(8'(expQ.size()), 8'h00);
    $display("bit read test done");
    test_done();
  end
endmodule : ibw_sequencer_bench
`default_nettype wire

// File: testbench/ibw_slave_model.sv
// I2C slave model on pulled-up clock and data lines
`timescale 1ns/100ps
`default_nettype none
module ibw_slave_model (
  input  wire logic       resetn,  // Async reset, active low
  input  wire logic       ackEn,   // Acknowledge the next byte
  input  wire logic [7:0] pinOut,  // Master pin values
  input  wire logic [7:0] pinOe,   // Master pin enables
  output var  logic [7:0] pinIn,   // Resolved pin levels
  output var  logic [7:0] rxByte   // Last byte received
);
  logic       scl;     // Clock line level
  logic       sda;     // Data line level
  logic       ackDrv;  // Slave pulls data low
  logic [3:0] bitCnt;  // Rising edges in this byte
  // Pull-ups win unless someone pulls low; data out is open drain
  assign scl   = pinOe[0] ? pinOut[0] : 1'h1;
  assign sda   = !(pinOe[1] && !pinOut[1]) && !ackDrv;
  assign pinIn = {5'h1F, sda, sda, scl};
  // Eight data bits shifted in, the ninth edge is the acknowledge
  always_ff @(posedge scl or negedge resetn) begin
    if (!resetn) begin
      bitCnt <= 4'h0;
      rxByte <= 8'h00;
    end else if (bitCnt == 4'h8) begin
      bitCnt <= 4'h0;
    end else begin
      bitCnt <= bitCnt + 4'h1;
      rxByte <= {rxByte[6:0], sda};
    end
  end
  // Acknowledge held across the whole ninth clock, released on its fall
  always_ff @(negedge scl or negedge resetn) begin
    if (!resetn) begin
      ackDrv <= 1'h0;
    end else begin
      ackDrv <= bitCnt == 4'h8 && ackEn;
    end
  end
endmodule : ibw_slave_model
`default_nettype wire
